// [shared/fpfc_pkg.sv]
package fpfc_pkg;

    // ------------------------------------------------------------
    // register port geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 6;
    localparam int DATA_W = 16;
    localparam int IDX_W = 3;
    localparam int TABLE_DEPTH = 8;
    localparam int PROFILES = 2;
    localparam int PIN_W = 7;

    // ------------------------------------------------------------
    // register indices
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] REG_MAIN = 6'h00;
    localparam logic [ADDR_W-1:0] REG_FSK_CFG = 6'h01;
    localparam logic [ADDR_W-1:0] REG_DEV_SEL = 6'h02;
    localparam logic [ADDR_W-1:0] REG_DIRECT = 6'h03;
    localparam logic [ADDR_W-1:0] REG_STATUS = 6'h04;
    localparam logic [ADDR_W-1:0] REG_DEV_OUT = 6'h05;
    localparam logic [ADDR_W-1:0] REG_TABLE = 6'h10;

    // ------------------------------------------------------------
    // main control fields
    // ------------------------------------------------------------
    localparam int BIT_CAL_EN = 0;
    localparam int FLD_RSVD_LO = 1;
    localparam int FLD_RSVD_HI = 5;
    localparam int BIT_PROFILE_SEL = 6;
    localparam int BIT_DUAL_CAL_EN = 7;
    localparam int BIT_SWITCH_SRC = 8;
    localparam int BIT_RECAL = 9;
    localparam int BIT_PORT_POL = 10;
    localparam int BIT_PORT_SRC = 11;
    localparam logic [4:0] RSVD_VALUE = 5'h01;
    localparam logic [DATA_W-1:0] MAIN_RESET = 16'h0003;
    localparam logic [DATA_W-1:0] MAIN_WMASK = 16'h0fff;

    // ------------------------------------------------------------
    // shift keying configuration fields
    // ------------------------------------------------------------
    localparam int BIT_MODE_LO = 0;
    localparam int BIT_MODE_HI = 1;
    localparam int FLD_LEVEL_LO = 2;
    localparam int FLD_LEVEL_HI = 3;
    localparam int BIT_EN_P0 = 4;
    localparam int BIT_EN_P1 = 5;
    localparam int BIT_PORT_TX = 6;
    localparam logic [DATA_W-1:0] FSK_CFG_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] FSK_CFG_WMASK = 16'h007f;

    // ------------------------------------------------------------
    // serial stream timing
    // ------------------------------------------------------------
    localparam int SER_HALF = 2;
    localparam logic [3:0] SER_LAST_BIT = 4'hf;

    typedef enum logic [1:0] {
        FPFC_MODE_PIN = 2'b00,
        FPFC_MODE_REG = 2'b01,
        FPFC_MODE_SERIAL = 2'b10,
        FPFC_MODE_DIRECT = 2'b11
    } fpfc_mode_t;

    typedef enum logic [1:0] {
        SER_IDLE,
        SER_LOW,
        SER_HIGH
    } fpfc_ser_state_t;

endpackage

// [shared/fpfc_if.sv]
`timescale 1ns/1ps
interface fpfc_if;
    import fpfc_pkg::*;
    // register port
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [DATA_W-1:0] reg_rdata;
    // control and modulation pins
    logic txrx_control_pin;
    logic [IDX_W-1:0] sym_idx;
    logic ser_clk;
    logic modulation_data_pin_one;
    logic ser_frame;

    modport dev (
        input reg_addr, reg_wdata, reg_wr, reg_rd,
        input txrx_control_pin, sym_idx, ser_clk,
        input modulation_data_pin_one, ser_frame,
        output reg_rdata
    );
    modport host (
        output reg_addr, reg_wdata, reg_wr, reg_rd,
        output txrx_control_pin, sym_idx, ser_clk,
        output modulation_data_pin_one, ser_frame,
        input reg_rdata
    );
endinterface

// [verilog/fpfc_device.sv]
`timescale 1ns/1ps
// Operation
// [R1] recal bit calibrates both; host clears it
// [R2] bit 8: profile switch by register or pin
// [R3] pin profile switching needs dual calibration enable
// [R4] bit 7: calibrate both profiles initially
// [R5] bit 6 selects profile one or two
// [R6] host writes 1h into bits 5:1
// [R7] bit 0 lets main writes start calibration
// [R8] deviations are two's complement step counts
// [R9] eight stored deviations per profile
// [R10] register mode applies indexed stored deviation
// [R11] direct mode applies written 16-bit step
// [R12] serial mode takes steps on data pin
// [R13] four levels: level two plus enable
// [R14] pin port control: match polarity means transmit
// [R15] pin toggles profile relative to select bit
// [R16] bit 11: port switch by register or pin
// [R17] bit 10: pin level meaning transmit
// [R18] plain main write recalibrates active profile only
module fpfc_device (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // link to the host
    fpfc_if.dev bus,
    // synthesizer side
    output logic o_profile,
    output logic o_transmit_output,
    output logic o_receive_output,
    output logic [fpfc_pkg::DATA_W-1:0] o_deviation,
    output logic o_cal_start,
    output logic [fpfc_pkg::PROFILES-1:0] o_cal_mask
);
    import fpfc_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [PIN_W-1:0] pin_s1_r;
    logic [PIN_W-1:0] pin_s2_r;
    logic ser_clk_d_r;
    logic [DATA_W-1:0] main_r;
    logic [DATA_W-1:0] cfg_r;
    logic [IDX_W-1:0] dev_sel_r;
    logic [DATA_W-1:0] direct_r;
    logic [DATA_W-1:0] table_r [PROFILES*TABLE_DEPTH];
    logic [DATA_W-1:0] ser_shift_r;
    logic [3:0] ser_cnt_r;
    logic [DATA_W-1:0] ser_word_r;
    logic pin_ref_r;
    logic init_done_r;
    logic [DATA_W-1:0] rdata_r;
    logic txrx_s;
    logic [IDX_W-1:0] sym_s;
    logic ser_clk_s;
    logic ser_data_s;
    logic ser_frame_s;
    logic main_wr;
    logic [DATA_W-1:0] main_nxt;
    logic profile_nxt;
    logic tx_nxt;
    fpfc_mode_t mode;
    logic [IDX_W-1:0] idx;
    logic shift_en;
    logic [DATA_W-1:0] dev_nxt;

    // index mask for the programmed level count; 0 keeps all eight
    function automatic logic [IDX_W-1:0] level_mask(input logic [1:0] lvl);
        unique case (lvl)
            2'h1: level_mask = 3'h1;
            2'h2: level_mask = 3'h3;
            2'h3: level_mask = 3'h7;
            2'h0: level_mask = 3'h7;
        endcase
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // pins are asynchronous to us, so two stages before any use
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
        end else begin
            pin_s1_r <= {bus.txrx_control_pin, bus.sym_idx, bus.ser_clk,
                         bus.modulation_data_pin_one, bus.ser_frame};
            pin_s2_r <= pin_s1_r;
        end
    end

    assign txrx_s = pin_s2_r[6];
    assign sym_s = pin_s2_r[5:3];
    assign ser_clk_s = pin_s2_r[2];
    assign ser_data_s = pin_s2_r[1];
    assign ser_frame_s = pin_s2_r[0];

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    assign main_wr = bus.reg_wr && (bus.reg_addr == REG_MAIN);
    assign main_nxt = bus.reg_wdata & MAIN_WMASK;

    // reserved field is stored as written; host keeps it at 1h
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            main_r <= MAIN_RESET;
            cfg_r <= FSK_CFG_RESET;
            dev_sel_r <= '0;
            direct_r <= '0;
        end else if (bus.reg_wr) begin
            unique case (bus.reg_addr)
                REG_MAIN: main_r <= main_nxt; // [R6]
                REG_FSK_CFG: cfg_r <= bus.reg_wdata & FSK_CFG_WMASK;
                REG_DEV_SEL: dev_sel_r <= bus.reg_wdata[IDX_W-1:0]; // [R10]
                REG_DIRECT: direct_r <= bus.reg_wdata; // [R11]
                default: ;
            endcase
        end
    end

    // deviation table: profile in the index msb, symbol in the rest
    generate
        for (genvar g = 0; g < PROFILES*TABLE_DEPTH; g++) begin : g_table
            always_ff @(posedge i_core_clk) begin
                if (!i_rst_n) begin
                    table_r[g] <= '0;
                end else if (bus.reg_wr &&
                             bus.reg_addr == REG_TABLE + ADDR_W'(g)) begin
                    table_r[g] <= bus.reg_wdata; // [R9] [R8]
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // profile and port selection
    // ------------------------------------------------------------
    // under pin control the select bit names the profile output at
    // the pin level seen on the last main write; each toggle swaps
    always_comb begin
        if (main_r[BIT_SWITCH_SRC]) begin // [R2]
            profile_nxt = main_r[BIT_PROFILE_SEL]
                          ^ (txrx_s ^ pin_ref_r); // [R15]
        end else begin
            profile_nxt = main_r[BIT_PROFILE_SEL]; // [R5]
        end
        if (main_r[BIT_PORT_SRC]) begin // [R16]
            tx_nxt = (txrx_s == main_r[BIT_PORT_POL]); // [R14] [R17]
        end else begin
            tx_nxt = cfg_r[BIT_PORT_TX];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            pin_ref_r <= 1'b0;
        end else if (main_wr) begin
            pin_ref_r <= txrx_s;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_profile <= 1'b0;
            o_transmit_output <= 1'b0;
            o_receive_output <= 1'b0;
        end else begin
            o_profile <= main_wr ? main_nxt[BIT_PROFILE_SEL] : profile_nxt;
            o_transmit_output <= tx_nxt;
            o_receive_output <= !tx_nxt;
        end
    end

    // ------------------------------------------------------------
    // calibration triggers
    // ------------------------------------------------------------
    // a profile switch calibrates only the newly chosen profile (both while recal is set),
    // starting from its stored data, which keeps switching short
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_cal_start <= 1'b0;
            o_cal_mask <= '0;
            init_done_r <= 1'b0;
        end else if (main_wr && main_nxt[BIT_CAL_EN]) begin // [R7]
            o_cal_start <= 1'b1;
            init_done_r <= 1'b1;
            if (main_nxt[BIT_RECAL] || // [R1]
                (!init_done_r && main_nxt[BIT_DUAL_CAL_EN])) begin // [R4]
                o_cal_mask <= 2'h3;
            end else if (main_nxt[BIT_PROFILE_SEL]) begin // [R18]
                o_cal_mask <= 2'h2;
            end else begin
                o_cal_mask <= 2'h1;
            end
        end else if (!main_wr && main_r[BIT_CAL_EN] &&
                     profile_nxt != o_profile) begin
            o_cal_start <= 1'b1;
            // recal left set makes every switch calibrate both
            o_cal_mask <= main_r[BIT_RECAL] ? 2'h3
                        : (profile_nxt ? 2'h2 : 2'h1); // [R1]
        end else begin
            o_cal_start <= 1'b0;
            o_cal_mask <= '0;
        end
    end

    // ------------------------------------------------------------
    // serial step stream
    // ------------------------------------------------------------
    // msb first, sampled on the synchronised rising clock edge
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            ser_clk_d_r <= 1'b0;
        end else begin
            ser_clk_d_r <= ser_clk_s;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            ser_shift_r <= '0;
            ser_cnt_r <= '0;
            ser_word_r <= '0;
        end else if (!ser_frame_s) begin
            ser_cnt_r <= '0; // partial words are dropped
        end else if (ser_clk_s && !ser_clk_d_r) begin // [R12]
            ser_shift_r <= {ser_shift_r[DATA_W-2:0], ser_data_s};
            ser_cnt_r <= ser_cnt_r + 4'h1;
            if (ser_cnt_r == SER_LAST_BIT) begin
                ser_word_r <= {ser_shift_r[DATA_W-2:0], ser_data_s};
            end
        end
    end

    // ------------------------------------------------------------
    // deviation output
    // ------------------------------------------------------------
    always_comb begin
        mode = fpfc_mode_t'({cfg_r[BIT_MODE_HI], cfg_r[BIT_MODE_LO]});
        shift_en = profile_nxt ? cfg_r[BIT_EN_P1] : cfg_r[BIT_EN_P0];
        idx = ((mode == FPFC_MODE_PIN) ? sym_s : dev_sel_r)
              & level_mask(cfg_r[FLD_LEVEL_HI:FLD_LEVEL_LO]); // [R13]
        unique case (mode)
            FPFC_MODE_PIN: dev_nxt = table_r[{profile_nxt, idx}]; // [R9]
            FPFC_MODE_REG: dev_nxt = table_r[{profile_nxt, idx}]; // [R10]
            FPFC_MODE_SERIAL: dev_nxt = ser_word_r; // [R12]
            FPFC_MODE_DIRECT: dev_nxt = direct_r; // [R11]
        endcase
        if (!shift_en) begin
            dev_nxt = '0;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_deviation <= '0;
        end else begin
            o_deviation <= dev_nxt;
        end
    end

    // ------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------
    // unmapped indices read zero, answer always one cycle later
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            rdata_r <= '0;
        end else if (bus.reg_rd) begin
            if (bus.reg_addr[5:4] == 2'h1) begin
                rdata_r <= table_r[bus.reg_addr[3:0]];
            end else begin
                unique case (bus.reg_addr)
                    REG_MAIN: rdata_r <= main_r;
                    REG_FSK_CFG: rdata_r <= cfg_r;
                    REG_DEV_SEL: rdata_r <= {13'h0000, dev_sel_r};
                    REG_DIRECT: rdata_r <= direct_r;
                    REG_STATUS: rdata_r <= {12'h000, init_done_r,
                                            o_receive_output,
                                            o_transmit_output, o_profile};
                    REG_DEV_OUT: rdata_r <= o_deviation;
                    default: rdata_r <= '0;
                endcase
            end
        end else begin
            rdata_r <= '0;
        end
    end

    assign bus.reg_rdata = rdata_r;

endmodule // fpfc_device

// [verilog/fpfc_host.sv]
`timescale 1ns/1ps
module fpfc_host (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // link to the device
    fpfc_if.host bus,
    // software command port
    input wire logic [fpfc_pkg::ADDR_W-1:0] i_cmd_addr,
    input wire logic [fpfc_pkg::DATA_W-1:0] i_cmd_wdata,
    input wire logic i_cmd_wr,
    input wire logic i_cmd_rd,
    output logic o_cmd_ready,
    output logic [fpfc_pkg::DATA_W-1:0] o_cmd_rdata,
    output logic o_cmd_rvalid,
    // control pin levels
    input wire logic i_txrx_level,
    input wire logic [fpfc_pkg::IDX_W-1:0] i_symbol,
    // serial step stream
    input wire logic [fpfc_pkg::DATA_W-1:0] i_stream_word,
    input wire logic i_stream_valid,
    output logic o_stream_ready
);
    import fpfc_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] addr_r;
    logic [DATA_W-1:0] wdata_r;
    logic wr_r;
    logic rd_r;
    logic rd_d_r;
    logic clr_pend_r;
    logic [DATA_W-1:0] main_last_r;
    logic [DATA_W-1:0] fixed;
    fpfc_ser_state_t ser_state_r;
    logic [DATA_W-1:0] ser_shift_r;
    logic [3:0] ser_bit_r;
    logic [1:0] ser_tick_r;
    logic ser_clk_r;
    logic ser_frame_r;
    logic txrx_r;
    logic [IDX_W-1:0] sym_r;

    // main control values are made legal before they leave
    function automatic logic [DATA_W-1:0] fix_main(input logic [DATA_W-1:0] v);
        fix_main = v;
        fix_main[FLD_RSVD_HI:FLD_RSVD_LO] = RSVD_VALUE; // [R6]
        if (v[BIT_SWITCH_SRC]) begin
            fix_main[BIT_DUAL_CAL_EN] = 1'b1; // [R3]
        end
    endfunction

    assign fixed = (i_cmd_addr == REG_MAIN) ? fix_main(i_cmd_wdata)
                                            : i_cmd_wdata;

    // ------------------------------------------------------------
    // register port master
    // ------------------------------------------------------------
    // a recal write is followed by a clearing write; commands stall
    // for that one cycle so the bit is never left set by accident
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            addr_r <= '0;
            wdata_r <= '0;
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            clr_pend_r <= 1'b0;
            main_last_r <= MAIN_RESET;
            o_cmd_ready <= 1'b1;
        end else if (clr_pend_r) begin
            addr_r <= REG_MAIN;
            wdata_r <= main_last_r & ~(16'h0001 << BIT_RECAL); // [R1]
            wr_r <= 1'b1;
            rd_r <= 1'b0;
            clr_pend_r <= 1'b0;
            o_cmd_ready <= 1'b1;
        end else begin
            addr_r <= i_cmd_addr;
            wdata_r <= fixed; // [R8] [R13]
            wr_r <= i_cmd_wr;
            rd_r <= i_cmd_rd && !i_cmd_wr;
            if (i_cmd_wr && i_cmd_addr == REG_MAIN) begin
                main_last_r <= fixed;
                clr_pend_r <= fixed[BIT_RECAL]; // [R1]
                o_cmd_ready <= !fixed[BIT_RECAL];
            end
        end
    end

    // read data three cycles after the request, one cycle long
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            rd_d_r <= 1'b0;
            o_cmd_rvalid <= 1'b0;
            o_cmd_rdata <= '0;
        end else begin
            rd_d_r <= rd_r;
            o_cmd_rvalid <= rd_d_r;
            o_cmd_rdata <= rd_d_r ? bus.reg_rdata : '0;
        end
    end

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            txrx_r <= 1'b0;
            sym_r <= '0;
        end else begin
            txrx_r <= i_txrx_level;
            sym_r <= i_symbol;
        end
    end

    // serial sender: data set while clock low, msb first
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            ser_state_r <= SER_IDLE;
            ser_shift_r <= '0;
            ser_bit_r <= '0;
            ser_tick_r <= '0;
            ser_clk_r <= 1'b0;
            ser_frame_r <= 1'b0;
            o_stream_ready <= 1'b1;
        end else begin
            unique case (ser_state_r)
                SER_IDLE: begin
                    ser_frame_r <= 1'b0;
                    ser_clk_r <= 1'b0;
                    if (i_stream_valid && o_stream_ready) begin
                        ser_shift_r <= i_stream_word; // [R12]
                        ser_bit_r <= '0;
                        ser_tick_r <= '0;
                        ser_frame_r <= 1'b1;
                        o_stream_ready <= 1'b0;
                        ser_state_r <= SER_LOW;
                    end else begin
                        o_stream_ready <= 1'b1;
                    end
                end
                SER_LOW: begin
                    ser_tick_r <= ser_tick_r + 2'h1;
                    if (ser_tick_r == 2'(SER_HALF - 1)) begin
                        ser_tick_r <= '0;
                        ser_clk_r <= 1'b1;
                        ser_state_r <= SER_HIGH;
                    end
                end
                SER_HIGH: begin
                    ser_tick_r <= ser_tick_r + 2'h1;
                    if (ser_tick_r == 2'(SER_HALF - 1)) begin
                        ser_tick_r <= '0;
                        ser_clk_r <= 1'b0;
                        ser_shift_r <= {ser_shift_r[DATA_W-2:0], 1'b0};
                        ser_bit_r <= ser_bit_r + 4'h1;
                        ser_state_r <= (ser_bit_r == SER_LAST_BIT)
                                       ? SER_IDLE : SER_LOW;
                    end
                end
                default: ser_state_r <= SER_IDLE;
            endcase
        end
    end

    assign bus.reg_addr = addr_r;
    assign bus.reg_wdata = wdata_r;
    assign bus.reg_wr = wr_r;
    assign bus.reg_rd = rd_r;
    assign bus.txrx_control_pin = txrx_r;
    assign bus.sym_idx = sym_r;
    assign bus.ser_clk = ser_clk_r;
    assign bus.modulation_data_pin_one = ser_shift_r[DATA_W-1];
    assign bus.ser_frame = ser_frame_r;

endmodule // fpfc_host

// [tb/fpfc_monitor.sv]
`timescale 1ns/1ps
// ------------------------------
// link checker
// ------------------------------
module fpfc_monitor (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // link signals
    input wire logic [fpfc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [fpfc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic ser_clk,
    input wire logic modulation_data_pin_one,
    input wire logic ser_frame
);
    import fpfc_pkg::*;
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);
    // main register writes as they cross the link
    wire logic mw = reg_wr && reg_addr == REG_MAIN;
    // halves of one serial bit cell
    sequence s_lo; ser_frame && !ser_clk; endsequence
    sequence s_hi; ser_frame && ser_clk; endsequence
    a_recal_clear: assert property (
        mw && reg_wdata[9] |=> mw && !reg_wdata[9]) else $error("recal kept");
    a_rsvd_one: assert property (
        mw |-> reg_wdata[5:1] == RSVD_VALUE) else $error("reserved field");
    a_pin_dual: assert property (
        mw && reg_wdata[8] |-> reg_wdata[7]) else $error("no dual cal");
    a_strobe_one: assert property (
        !(reg_wr && reg_rd)) else $error("two strobes");
    a_cell_shape: assert property (
        $rose(ser_frame) |-> s_lo [*2] ##1 s_hi [*2] ##1 s_lo)
        else $error("cell");
    a_frame_len: assert property (
        $rose(ser_frame) |-> ##[60:70] $fell(ser_frame)) else $error("frame");
    a_data_hold: assert property (
        s_hi |-> $stable(modulation_data_pin_one)) else $error("data moved");
    a_clk_idle: assert property (
        !ser_frame |-> !ser_clk) else $error("clock outside frame");
endmodule // fpfc_monitor

// [tb/freq_profile_fsk_control_test.sv]
`timescale 1ns/1ps
// ------------------------------
// host and device back to back
// ------------------------------
module freq_profile_fsk_control_test;
    import fpfc_pkg::*;
    logic clk = 0, rst_n = 0, cwr = 0, crd = 0, sv = 0, pin = 0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wd = '0, sw = '0, dev, rdat;
    logic [IDX_W-1:0] sym = '0;
    logic prof, tx, rx, cal, rv, srdy, rdy;
    logic [1:0] mask;
    logic [31:0] cal_e[$], cal_g[$], g;
    int miscompares = 0, n_checks = 0, seed = 32'h92b6, n, t;
    int cv[5] = '{'h83, 3, 'h43, 'h42, 'h283};
    int cf[5] = '{'h3c, 'h3d, 'h38, 'h39, 'h10};
    // model state mirroring the register file
    int m_main = 3, m_cfg = 0, m_sel = 0, m_dir = 0, m_ser = 0, m_pm = 0;
    int tbl[2][8];
    bit first = 1;
    fpfc_if link ();
    fpfc_device fpfc_device_i (.i_core_clk(clk), .i_rst_n(rst_n),
        .bus(link.dev), .o_profile(prof), .o_transmit_output(tx),
        .o_receive_output(rx), .o_deviation(dev), .o_cal_start(cal),
        .o_cal_mask(mask));
    fpfc_host fpfc_host_i (.i_core_clk(clk), .i_rst_n(rst_n), .bus(link.host),
        .i_cmd_addr(addr), .i_cmd_wdata(wd), .i_cmd_wr(cwr), .i_cmd_rd(crd),
        .o_cmd_ready(rdy), .o_cmd_rdata(rdat), .o_cmd_rvalid(rv),
        .i_txrx_level(pin), .i_symbol(sym), .i_stream_word(sw),
        .i_stream_valid(sv), .o_stream_ready(srdy));
    fpfc_monitor fpfc_monitor_i (.i_core_clk(clk), .i_rst_n(rst_n),
        .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata),
        .reg_wr(link.reg_wr), .reg_rd(link.reg_rd), .ser_clk(link.ser_clk),
        .modulation_data_pin_one(link.modulation_data_pin_one),
        .ser_frame(link.ser_frame));
    initial forever #5 clk = ~clk;
    // calibration pulses in arrival order
    always @(posedge clk) if (cal === 1'b1) cal_g.push_back(32'(mask));
    task automatic cmp(input logic [31:0] gv, input logic [31:0] ev);
        n_checks++;
        if (gv !== ev) begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, gv, ev);
        end
    endtask
    task automatic test_done();
        if (miscompares == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // pin mode flips the profile when the pin left its captured level
    function automatic int m_prof(input logic pv);
        return m_main[8] ? m_main[6] ^ (pv != m_pm) : m_main[6];
    endfunction
    function automatic int m_dev();
        int p = m_prof(pin), k = m_cfg[3:2] == 1 ? 1 : m_cfg[3:2] == 2 ? 3 : 7;
        if (!m_cfg[4 + p]) return 0;
        return m_cfg[1:0] == 0 ? tbl[p][sym & k] : m_cfg[1:0] == 1 ?
            tbl[p][m_sel & k] : m_cfg[0] ? m_dir : m_ser;
    endfunction
    // settle, then compare every device output with the model
    task automatic chk();
        repeat (8) @(posedge clk);
        t = m_main[11] ? pin == m_main[10] : m_cfg[6];
        cmp(prof, m_prof(pin));
        cmp({tx, rx}, t ? 2 : 1);
        cmp(dev, m_dev());
        while (cal_e.size() || cal_g.size()) begin
            g = cal_g.size() ? cal_g.pop_front() : 'h99;
            cmp(g, cal_e.size() ? cal_e.pop_front() : 'h88);
        end
    endtask
    task automatic wr(input int a, input int d);
        @(posedge clk);
        addr <= 6'(a);
        wd <= 16'(d);
        cwr <= 1;
        @(posedge clk);
        cwr <= 0;
        #1 cmp(rdy, a != 0 || !d[9]);
        if (a == REG_MAIN) begin
            d[7] |= d[8];
            if (d[0]) begin
                cal_e.push_back(d[9] || first && d[7] ? 3 : 1 << d[6]);
                first = 0;
            end
            if (d[9] && d[0]) cal_e.push_back(1 << d[6]);
            m_main = d & 'hdff;
            m_pm = pin;
        end
        if (a == REG_FSK_CFG) m_cfg = d & 'h7f;
        if (a == REG_DEV_SEL) m_sel = d & 7;
        if (a == REG_DIRECT) m_dir = d & 'hffff;
        if (a >= REG_TABLE) tbl[a[3]][a & 7] = d & 'hffff;
        repeat (2) @(posedge clk);
    endtask
    // read data come three cycles after the command
    task automatic rd_chk(input int a, input int e);
        @(posedge clk);
        addr <= 6'(a);
        crd <= 1;
        @(posedge clk);
        crd <= 0;
        repeat (2) @(posedge clk);
        #1 cmp({rv, rdat}, 'h10000 | e);
    endtask
    task automatic set_pin(input logic v);
        int p = m_prof(pin);
        pin <= v;
        if (p != m_prof(v) && m_main[0])
            cal_e.push_back(m_main[9] ? 3 : 1 << m_prof(v));
        chk();
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1;
        chk();
        rd_chk(REG_MAIN, 3);
        foreach (cv[i]) begin
            wr(REG_MAIN, cv[i]);
            chk();
        end
        rd_chk(REG_MAIN, m_main);
        for (int i = 0; i < 16; i++) wr('h10 + i, $random(seed));
        rd_chk('h3f, 0);
        for (int p = 0; p < 2; p++) begin
            wr(REG_MAIN, 3 | p << 6);
            for (int c = 0; c < 5; c++) begin
                wr(REG_FSK_CFG, cf[c]);
                for (int i = 0; i < 8; i++) begin
                    sym <= 3'(i);
                    wr(REG_DEV_SEL, 7 - i);
                    chk();
                end
            end
        end
        // direct and serial steps in turn
        for (int i = 0; i < 4; i++) begin
            wr(REG_FSK_CFG, 'h33 - i % 2);
            wr(REG_DIRECT, $random(seed));
            sw <= 16'($random(seed));
            sv <= 1;
            @(posedge clk);
            sv <= 0;
            m_ser = sw;
            n = 0;
            repeat (2) @(posedge clk);
            while (srdy !== 1'b1) begin
                @(posedge clk);
                n++;
                if (n > 200) begin
                    miscompares++;
                    test_done();
                end
            end
            chk();
        end
        for (int i = 0; i < 8; i++) begin
            wr(REG_MAIN, 'h803 | (i & 1) << 10 | (i & 2) << 7 | (i & 4) << 4);
            set_pin(1);
            set_pin(0);
        end
        wr(REG_MAIN, 3);
        wr(REG_FSK_CFG, 'h40);
        chk();
        test_done();
    end
endmodule // freq_profile_fsk_control_test
